// ===== logic/fspc_defs.svh
// constants of the flash self-programming controller
`ifndef FSPC_DEFS_SVH
`define FSPC_DEFS_SVH

// core-side register indices
`define FSPC_REG_ADDR_LOW 3'h0
`define FSPC_REG_ADDR_HIGH 3'h1
`define FSPC_REG_DATA_LOW 3'h2
`define FSPC_REG_DATA_HIGH 3'h3
`define FSPC_REG_CTRL 3'h4
`define FSPC_REG_KEY 3'h5

// control register bit positions
`define FSPC_CTRL_READ 0
`define FSPC_CTRL_WRITE 1
`define FSPC_CTRL_PERMIT 2
`define FSPC_CTRL_ABORT 3
`define FSPC_CTRL_ERASE 4
`define FSPC_CTRL_LATCH_ONLY 5
`define FSPC_CTRL_CFG_SEL 6

`define FSPC_KEY_FIRST 8'h55
`define FSPC_KEY_SECOND 8'haa
`define FSPC_BLANK_WORD 14'h3fff
`define FSPC_DATA_WIDTH 14
`define FSPC_ADDR_WIDTH 15
`define FSPC_ROW_WORDS 32
`define FSPC_ROW_BITS 5

// flash busy time, typical, and clock rate
`define FSPC_ERASE_TIME_US 2000
`define FSPC_CLK_MHZ 250
`define FSPC_ERASE_CYCLES (`FSPC_ERASE_TIME_US * `FSPC_CLK_MHZ)
`define FSPC_FORCED_NOPS 2

// controller-side AXI register offsets
`define FSPC_AXI_CMD 8'h00
`define FSPC_AXI_ADDR 8'h04
`define FSPC_AXI_WDATA 8'h08
`define FSPC_AXI_STATUS 8'h0c
`define FSPC_AXI_RDATA 8'h10

`endif

// ===== logic/fspc_device.sv
// flash self-programming controller with its flash array
`timescale 1ns/1ns
`default_nettype none
`include "fspc_defs.svh"
module fspc_device #(
    parameter int ERASE_CYCLES = `FSPC_ERASE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    fspc_if.device bus,
    output logic busy,
    output logic [`FSPC_ADDR_WIDTH-1:0] flash_addr_seen
);
    logic [7:0] flash_addr_low;
    logic [6:0] flash_addr_high;
    logic [7:0] flash_data_low;
    logic [5:0] flash_data_high;
    logic rd_trig;
    logic wr_trig;
    logic write_permit;
    bit write_abort_flag;
    logic erase_sel;
    logic latch_only;
    logic config_space_select;
    logic [1:0] key_step;
    logic [1:0] nop_cnt;
    logic [31:0] busy_cnt;
    logic op_erase;
    logic op_latch;
    logic [7:0] next_rd_data;
    fspc_pkg::fspc_state_type state;
    logic [`FSPC_DATA_WIDTH-1:0] mem [0:255];
    logic [`FSPC_DATA_WIDTH-1:0] latch [0:`FSPC_ROW_WORDS-1];
    logic [`FSPC_ADDR_WIDTH-1:0] word_addr;
    logic ctrl_wr;
    logic trig_wr;
    logic trig_ok;

    assign word_addr = {flash_addr_high, flash_addr_low};
    assign ctrl_wr = bus.wr_en && bus.reg_addr == `FSPC_REG_CTRL;
    assign trig_wr = ctrl_wr && bus.wr_data[`FSPC_CTRL_WRITE] && !wr_trig
        && state == fspc_pkg::FSPC_IDLE;
    assign trig_ok = trig_wr && write_permit && key_step == 2'h2
        && !config_space_select;

    // ----------------------------------------
    // register writes by the core
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flash_addr_low <= 8'h00;
            flash_addr_high <= 7'h00;
        end
        else if (bus.wr_en && state == fspc_pkg::FSPC_IDLE)
        begin
            if (bus.reg_addr == `FSPC_REG_ADDR_LOW)
                flash_addr_low <= bus.wr_data;
            if (bus.reg_addr == `FSPC_REG_ADDR_HIGH)
                flash_addr_high <= bus.wr_data[6:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            write_permit <= 1'b0;
            erase_sel <= 1'b0;
            latch_only <= 1'b0;
            config_space_select <= 1'b0;
        end
        else if (ctrl_wr && state == fspc_pkg::FSPC_IDLE)
        begin
            write_permit <= bus.wr_data[`FSPC_CTRL_PERMIT];
            erase_sel <= bus.wr_data[`FSPC_CTRL_ERASE];
            latch_only <= bus.wr_data[`FSPC_CTRL_LATCH_ONLY];
            config_space_select <= bus.wr_data[`FSPC_CTRL_CFG_SEL];
        end
    end

    // abort flag: a reset that lands mid-write sets it; two-state so a cold start reads clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            write_abort_flag <= write_abort_flag | wr_trig;
        else if (ctrl_wr && !bus.wr_data[`FSPC_CTRL_ABORT])
            write_abort_flag <= 1'b0;
    end

    // key tracker: any other write in between breaks the sequence
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            key_step <= 2'h0;
        else if (bus.wr_en)
        begin
            if (bus.reg_addr == `FSPC_REG_KEY && bus.wr_data == `FSPC_KEY_FIRST)
                key_step <= 2'h1;
            else if (bus.reg_addr == `FSPC_REG_KEY && bus.wr_data == `FSPC_KEY_SECOND
                && key_step == 2'h1)
                key_step <= 2'h2;
            else
                key_step <= 2'h0;
        end
        else if (bus.rd_en)
            key_step <= 2'h0;
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= fspc_pkg::FSPC_IDLE;
            rd_trig <= 1'b0;
            wr_trig <= 1'b0;
            nop_cnt <= 2'h0;
            busy_cnt <= 32'h0;
            op_erase <= 1'b0;
            op_latch <= 1'b0;
        end
        else
        begin
            case (state)
                fspc_pkg::FSPC_IDLE:
                begin
                    if (ctrl_wr && bus.wr_data[`FSPC_CTRL_READ])
                    begin
                        rd_trig <= 1'b1;
                        state <= fspc_pkg::FSPC_READ;
                    end
                    else if (trig_ok)
                    begin
                        wr_trig <= 1'b1;
                        op_erase <= erase_sel;
                        op_latch <= latch_only && !erase_sel;
                        nop_cnt <= 2'(`FSPC_FORCED_NOPS);
                        state <= fspc_pkg::FSPC_NOPS;
                    end
                end
                fspc_pkg::FSPC_READ:
                begin
                    // one slot void while the array is fetched
                    rd_trig <= 1'b0;
                    state <= fspc_pkg::FSPC_IDLE;
                end
                fspc_pkg::FSPC_NOPS:
                begin
                    nop_cnt <= nop_cnt - 2'h1;
                    if (nop_cnt == 2'h1)
                    begin
                        if (op_latch)
                            state <= fspc_pkg::FSPC_DONE;
                        else
                        begin
                            busy_cnt <= ERASE_CYCLES;
                            state <= fspc_pkg::FSPC_BUSY;
                        end
                    end
                end
                fspc_pkg::FSPC_BUSY:
                begin
                    // clocks keep running; only the core is held
                    busy_cnt <= busy_cnt - 32'h1;
                    if (busy_cnt == 32'h1)
                        state <= fspc_pkg::FSPC_DONE;
                end
                fspc_pkg::FSPC_DONE:
                begin
                    wr_trig <= 1'b0;
                    state <= fspc_pkg::FSPC_IDLE;
                end
                default:
                    state <= fspc_pkg::FSPC_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // data pair, array and latches
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flash_data_low <= 8'h00;
            flash_data_high <= 6'h00;
        end
        else if (state == fspc_pkg::FSPC_READ)
            {flash_data_high, flash_data_low} <= mem[word_addr[7:0]];
        else if (bus.wr_en && state == fspc_pkg::FSPC_IDLE)
        begin
            if (bus.reg_addr == `FSPC_REG_DATA_LOW)
                flash_data_low <= bus.wr_data;
            if (bus.reg_addr == `FSPC_REG_DATA_HIGH)
                flash_data_high <= bus.wr_data[5:0];
        end
    end

    // array model: blank after reset, erase whole rows, program from latches
    genvar gi;
    generate
        for (gi = 0; gi < `FSPC_ROW_WORDS; gi = gi + 1)
        begin : g_row
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    latch[gi] <= `FSPC_BLANK_WORD;
                else if (state == fspc_pkg::FSPC_NOPS && nop_cnt == 2'h1 && op_latch
                    && word_addr[`FSPC_ROW_BITS-1:0] == gi)
                    latch[gi] <= {flash_data_high, flash_data_low};
                else if (state == fspc_pkg::FSPC_BUSY && busy_cnt == 32'h1)
                    latch[gi] <= `FSPC_BLANK_WORD;
            end
        end
        for (gi = 0; gi < 256; gi = gi + 1)
        begin : g_word
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    mem[gi] <= `FSPC_BLANK_WORD;
                else if (state == fspc_pkg::FSPC_BUSY && busy_cnt == 32'h1
                    && word_addr[7:`FSPC_ROW_BITS] == 3'(gi / `FSPC_ROW_WORDS))
                    mem[gi] <= op_erase ? `FSPC_BLANK_WORD
                        : latch[gi % `FSPC_ROW_WORDS];
            end
        end
    endgenerate

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb
    begin
        case (bus.reg_addr)
            `FSPC_REG_ADDR_LOW: next_rd_data = flash_addr_low;
            `FSPC_REG_ADDR_HIGH: next_rd_data = {1'b0, flash_addr_high};
            `FSPC_REG_DATA_LOW: next_rd_data = flash_data_low;
            `FSPC_REG_DATA_HIGH: next_rd_data = {2'b00, flash_data_high};
            `FSPC_REG_CTRL: next_rd_data = {1'b1, config_space_select, latch_only,
                erase_sel, write_abort_flag, write_permit, wr_trig, rd_trig};
            default: next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bus.rd_data <= 8'h00;
            bus.stall <= 1'b0;
            bus.slot_void <= 1'b0;
            busy <= 1'b0;
            flash_addr_seen <= '0;
        end
        else
        begin
            bus.rd_data <= next_rd_data;
            bus.stall <= (state == fspc_pkg::FSPC_NOPS && nop_cnt == 2'h1 && !op_latch)
                || (state == fspc_pkg::FSPC_BUSY && busy_cnt != 32'h1);
            bus.slot_void <= (state == fspc_pkg::FSPC_IDLE
                && ((ctrl_wr && bus.wr_data[`FSPC_CTRL_READ]) || trig_ok))
                || (state == fspc_pkg::FSPC_NOPS && nop_cnt == 2'h2);
            busy <= state != fspc_pkg::FSPC_IDLE;
            flash_addr_seen <= word_addr;
        end
    end
endmodule
`default_nettype wire

// ===== logic/fspc_host.sv
// host end: AXI4-Lite slave that runs core-side sequences
`timescale 1ns/1ns
`default_nettype none
`include "fspc_defs.svh"
module fspc_host (
    input wire logic aclk,
    input wire logic aresetn,
    fspc_if.host bus,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    fspc_pkg::fspc_host_state_type state;
    logic [7:0] aw_addr;
    logic aw_have;
    logic w_have;
    logic [31:0] w_data;
    logic [2:0] cmd_reg;
    logic [7:0] cmd_data;
    logic [3:0] seq_len;
    logic [3:0] seq_pos;
    logic [7:0] rd_word;
    logic [1:0] rd_wait;
    logic rd_pend;
    logic [1:0] resp;

    // write channels: each taken on its own, then executed
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (state == fspc_pkg::FSPC_H_RESP && s_axi_bvalid && s_axi_bready)
            begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // sequencer onto the core port
    // ----------------------------------------
    // cmd: [2:0] register, [15:8] byte; cmd 3'h7 runs the unlock triple.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= fspc_pkg::FSPC_H_IDLE;
            bus.wr_en <= 1'b0;
            bus.rd_en <= 1'b0;
            bus.reg_addr <= 3'h0;
            bus.wr_data <= 8'h00;
            seq_len <= 4'h0;
            seq_pos <= 4'h0;
            rd_wait <= 2'h0;
            rd_pend <= 1'b0;
            rd_word <= 8'h00;
            resp <= 2'b00;
            cmd_reg <= 3'h0;
            cmd_data <= 8'h00;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
        else
        begin
            bus.wr_en <= 1'b0;
            bus.rd_en <= 1'b0;
            case (state)
                fspc_pkg::FSPC_H_IDLE:
                begin
                    if (aw_have && w_have)
                    begin
                        resp <= 2'b00;
                        cmd_reg <= w_data[2:0];
                        cmd_data <= w_data[15:8];
                        seq_pos <= 4'h0;
                        if (aw_addr == `FSPC_AXI_CMD && w_data[2:0] == 3'h7)
                            seq_len <= 4'h3;
                        else if (aw_addr == `FSPC_AXI_CMD)
                            seq_len <= 4'h1;
                        else if (aw_addr == `FSPC_AXI_RDATA)
                            seq_len <= 4'h1;
                        else
                        begin
                            seq_len <= 4'h0;
                            resp <= 2'b10;
                        end
                        if (aw_addr == `FSPC_AXI_RDATA)
                            rd_pend <= 1'b1;
                        state <= fspc_pkg::FSPC_H_ISSUE;
                    end
                end
                fspc_pkg::FSPC_H_ISSUE:
                begin
                    if (seq_pos == seq_len)
                        state <= fspc_pkg::FSPC_H_RESP;
                    else if (!bus.stall)
                    begin
                        seq_pos <= seq_pos + 4'h1;
                        if (rd_pend)
                        begin
                            bus.rd_en <= 1'b1;
                            bus.reg_addr <= cmd_reg;
                        end
                        else if (seq_len == 4'h3)
                        begin
                            bus.wr_en <= 1'b1;
                            bus.reg_addr <= seq_pos == 4'h2 ? `FSPC_REG_CTRL : `FSPC_REG_KEY;
                            bus.wr_data <= seq_pos == 4'h0 ? `FSPC_KEY_FIRST
                                : (seq_pos == 4'h1 ? `FSPC_KEY_SECOND : cmd_data);
                        end
                        else
                        begin
                            bus.wr_en <= 1'b1;
                            bus.reg_addr <= cmd_reg;
                            bus.wr_data <= cmd_data;
                        end
                        // after every access, idle at least four slots
                        rd_wait <= 2'h3;
                        state <= fspc_pkg::FSPC_H_WAIT;
                    end
                end
                fspc_pkg::FSPC_H_WAIT:
                begin
                    rd_wait <= rd_wait - 2'h1;
                    if (rd_wait == 2'h1)
                    begin
                        if (rd_pend)
                        begin
                            rd_word <= bus.rd_data;
                            rd_pend <= 1'b0;
                        end
                        state <= fspc_pkg::FSPC_H_SEQ;
                    end
                end
                fspc_pkg::FSPC_H_SEQ:
                begin
                    if (!bus.stall)
                        state <= fspc_pkg::FSPC_H_ISSUE;
                end
                fspc_pkg::FSPC_H_RESP:
                begin
                    s_axi_bvalid <= 1'b1;
                    s_axi_bresp <= resp;
                    if (s_axi_bvalid && s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        state <= fspc_pkg::FSPC_H_IDLE;
                    end
                end
                default:
                    state <= fspc_pkg::FSPC_H_IDLE;
            endcase
        end
    end

    // read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    `FSPC_AXI_STATUS: s_axi_rdata <= {30'h0, bus.stall,
                        state != fspc_pkg::FSPC_H_IDLE};
                    `FSPC_AXI_RDATA: s_axi_rdata <= {24'h0, rd_word};
                    default:
                    begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== logic/fspc_if.sv
// core-side register port between host controller and flash controller
`timescale 1ns/1ns
`default_nettype none
interface fspc_if;
    logic wr_en;
    logic rd_en;
    logic [2:0] reg_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic stall;
    logic slot_void;

    modport device (
        input wr_en,
        input rd_en,
        input reg_addr,
        input wr_data,
        output rd_data,
        output stall,
        output slot_void
    );
    modport host (
        output wr_en,
        output rd_en,
        output reg_addr,
        output wr_data,
        input rd_data,
        input stall,
        input slot_void
    );
endinterface
`default_nettype wire

// ===== logic/fspc_pkg.sv
// types shared by both ends of the flash self-programming link
`default_nettype none
package fspc_pkg;
    typedef enum logic [4:0] {
        FSPC_IDLE = 5'b00001,
        FSPC_READ = 5'b00010,
        FSPC_NOPS = 5'b00100,
        FSPC_BUSY = 5'b01000,
        FSPC_DONE = 5'b10000
    } fspc_state_type;

    typedef enum logic [5:0] {
        FSPC_H_IDLE = 6'b000001,
        FSPC_H_ISSUE = 6'b000010,
        FSPC_H_WAIT = 6'b000100,
        FSPC_H_SEQ = 6'b001000,
        FSPC_H_RESP = 6'b010000,
        FSPC_H_RDRESP = 6'b100000
    } fspc_host_state_type;
endpackage
`default_nettype wire

// ===== tb/fspc_bench.sv
// bench joining host and device ends over the core port
`timescale 1ns/1ns
`default_nettype none
module fspc_bench;
    localparam int EC = 20;
    // an unlock triple alone ends inside LIM; a row stall of EC cycles runs past it
    localparam int LIM = EC + EC / 2;
    logic aclk = 0;
    logic aresetn = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, v;
    logic [31:0] wdata = 32'h0, rdata, rdv;
    logic awready, wready, bvalid, arready, rvalid, busy;
    logic [1:0] bresp, rresp, rr;
    logic [14:0] seen_addr;
    logic [13:0] w;
    int err_total = 0, tests_run = 0, cyc;
    fspc_if bus ();
    fspc_device #(.ERASE_CYCLES(EC)) i_fspc_device (.aclk(aclk), .aresetn(aresetn),
        .bus(bus), .busy(busy), .flash_addr_seen(seen_addr));
    fspc_host i_fspc_host (.aclk(aclk), .aresetn(aresetn), .bus(bus),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    fspc_chk #(.ERASE_CYCLES(EC)) i_fspc_chk (.aclk(aclk), .aresetn(aresetn),
        .wr_en(bus.wr_en), .rd_en(bus.rd_en), .reg_addr(bus.reg_addr),
        .wr_data(bus.wr_data), .rd_data(bus.rd_data), .stall(bus.stall),
        .slot_void(bus.slot_void));
    // --------
    // bus tasks
    // --------
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic issue(input logic [7:0] a, input logic [31:0] d);
        bit aw_ok = 0, w_ok = 0;
        cyc = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            cyc++;
            aw_ok |= awvalid && awready;
            w_ok |= wvalid && wready;
            if (aw_ok) awvalid <= 0;
            if (w_ok) wvalid <= 0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bready <= 1;
        issue(a, d);
        while (!bvalid)
        begin
            @(posedge aclk);
            cyc++;
        end
        check("bresp", bresp, 2'b00);
        bready <= 0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        while (!rvalid) @(posedge aclk);
        rdv = rdata;
        rr = rresp;
        rready <= 0;
        @(posedge aclk);
    endtask
    task automatic cmd(input logic [2:0] r, input logic [7:0] b);
        wr(8'h00, {16'h0000, b, 5'h00, r});
    endtask
    task automatic peek(input logic [2:0] r);
        wr(8'h10, {29'h0, r});
        rd(8'h10);
        v = rdv[7:0];
    endtask
    task automatic rdw(input logic [7:0] a);
        cmd(3'h0, a);
        cmd(3'h1, 8'h00);
        cmd(3'h4, 8'h01);
        peek(3'h2);
        w[7:0] = v;
        peek(3'h3);
        w[13:8] = v[5:0];
    endtask
    // keyed operation; permit and mode bits set first
    task automatic op(input logic [7:0] a, input logic [13:0] d, input logic [7:0] c);
        cmd(3'h0, a);
        cmd(3'h1, 8'h00);
        cmd(3'h2, d[7:0]);
        cmd(3'h3, {2'b00, d[13:8]});
        cmd(3'h4, c & 8'hfd);
        cmd(3'h7, c);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // --------
    // sequence
    // --------
    initial
    begin
        forever #2 aclk = ~aclk;
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        err_total++;
        end_of_test();
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        peek(3'h4);
        check("ctrl", v, 8'h80);
        peek(3'h5);
        check("key", v, 8'h00);
        cmd(3'h0, 8'h21);
        cmd(3'h1, 8'hff);
        check("addr", seen_addr, 15'h7f21);
        op(8'h50, 14'h0, 8'h16);
        check("erase stall", cyc > LIM, 1);
        peek(3'h4);
        check("write bit", v[1], 0);
        cmd(3'h0, 8'h46);
        cmd(3'h2, 8'h23);
        cmd(3'h4, 8'h06);
        check("no key", cyc < EC, 1);
        rdw(8'h46);
        check("no key word", w, 14'h3fff);
        op(8'h45, 14'h1555, 8'h26);
        check("latch", cyc < LIM, 1);
        op(8'h40, 14'h0000, 8'h06);
        check("prog stall", cyc > LIM, 1);
        op(8'h62, 14'h0abc, 8'h26);
        op(8'h61, 14'h2aaa, 8'h26);
        op(8'h60, 14'h0000, 8'h06);
        rdw(8'h45);
        check("word 45", w, 14'h1555);
        rdw(8'h62);
        check("word 62", w, 14'h0abc);
        rdw(8'h61);
        cmd(3'h0, 8'h45);
        peek(3'h2);
        check("hold", v, 8'haa);
        op(8'h5f, 14'h0, 8'h16);
        rdw(8'h45);
        check("row erased", w, 14'h3fff);
        rdw(8'h61);
        check("next row", w, 14'h2aaa);
        rd(8'h20);
        check("unmapped", rr, 2'b10);
        cmd(3'h4, 8'h14);
        issue(8'h00, 32'h0000_1607);
        repeat (16) @(posedge aclk);
        check("busy", busy, 1);
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        peek(3'h4);
        check("abort", v[3], 1);
        end_of_test();
    end
endmodule
`default_nettype wire

// ===== tb/fspc_chk.sv
// checker for the core-side register port
`timescale 1ns/1ns
`default_nettype none
module fspc_chk #(
    parameter int ERASE_CYCLES = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic stall,
    input wire logic slot_void
);
    logic [10:0] w1;
    logic [10:0] w2;
    logic [31:0] cnt;
    logic keys;
    logic trig;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // last two core writes must be the key pair
    assign keys = (w2 == 11'h555) && (w1 == 11'h5aa);
    assign trig = wr_en && reg_addr == 3'h4 && wr_data[1] && wr_data[2] && !wr_data[6] && keys;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w1 <= 11'h000;
            w2 <= 11'h000;
        end
        else if (wr_en)
        begin
            w1 <= {reg_addr, wr_data};
            w2 <= w1;
        end
    end
    always_ff @(posedge aclk)
    begin
        cnt <= (!aresetn || !stall) ? 32'h0 : cnt + 32'h1;
    end
    AST_KEY_ZERO: assert property (rd_en && reg_addr == 3'h5 |=> rd_data == 8'h00)
        else $error("key register read not zero");
    AST_FORCED_SLOT: assert property (trig |=> slot_void)
        else $error("no forced slot after trigger");
    AST_NO_KEY_NO_SLOT: assert property (wr_en && reg_addr == 3'h4 && wr_data[1] && !keys |=> !slot_void)
        else $error("trigger accepted without keys");
    AST_ROW_STALL: assert property (trig && !wr_data[5] |-> ##3 stall)
        else $error("row operation did not stall");
    AST_LATCH_FREE: assert property (trig && wr_data[5] |-> ##1 !stall [*4])
        else $error("latch load stalled");
    AST_STALL_SPAN: assert property ($fell(stall) |-> cnt >= ERASE_CYCLES - 1 && cnt <= ERASE_CYCLES + 2)
        else $error("stall length wrong");
    AST_STALL_CAUSE: assert property ($rose(stall) |-> $past(trig, 3))
        else $error("stall without unlock");
    AST_QUIET_STALL: assert property (stall |-> !wr_en && !rd_en)
        else $error("core access while stalled");
    AST_READ_NOPS: assert property (wr_en && reg_addr == 3'h4 && wr_data[0] |=> !wr_en [*2])
        else $error("access right after read trigger");
    AST_KEY_ORDER: assert property (wr_en && reg_addr == 3'h5 && wr_data == 8'haa |-> w1 == 11'h555)
        else $error("second key out of order");
    cover property (trig && wr_data[4]);
    cover property (trig && wr_data[5]);
    cover property ($fell(stall));
endmodule
`default_nettype wire
